// [ram_write_guard_pkg.sv]
// Contract
// - with a nonzero span selected, writes inside the guarded span are discarded.
// - span field 00 off, 01 128 bytes, 10 256 bytes, 11 512 bytes.
// - base register gives start address bits 15..8; span begins there.
// - only the first base write after reset is taken; later ones ignored.
// - start address is f, base byte, then 00h.
// - both registers are accessed with 8-bit accesses only.
// - single-step debug writes into the guarded span still take effect.
package ram_write_guard_pkg;

    localparam int          ADDR_W             = 20;
    localparam logic [19:0] GUARD_CTRL_ADDR    = 20'hf0078;
    localparam logic [19:0] BASE_SEL_ADDR      = 20'hff076;
    localparam logic [7:0]  GUARD_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  BASE_SEL_RESET     = 8'hef;
    localparam logic [7:0]  GUARD_CTRL_MASK    = 8'hb7;
    localparam int          SPAN_LSB           = 4;
    localparam logic [3:0]  RAM_TOP_NIBBLE     = 4'hf;
    localparam logic [1:0]  SPAN_OFF           = 2'h0;
    localparam logic [1:0]  SPAN_128           = 2'h1;
    localparam logic [1:0]  SPAN_256           = 2'h2;
    localparam logic [1:0]  SPAN_512           = 2'h3;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        debug_step;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } mem_req_type;

endpackage

// [span_match.sv]
`timescale 1ns/100ps
`default_nettype none
module span_match #(
    parameter int ADDR_W = 20
) (
    input  wire logic [ADDR_W-1:0] addr,     // access address
    input  wire logic [7:0]        base,     // base byte
    input  wire logic [1:0]        span,     // span select
    output logic                   hit       // address inside span
);
    if (ADDR_W != 20)
    begin : g_bad_addr_w
        $error("span_match needs 20-bit addresses");
    end

    logic [19:0] start;
    logic [19:0] offs;

    always_comb
    begin
        start = {ram_write_guard_pkg::RAM_TOP_NIBBLE, base, 8'h00};
        offs  = addr - start;
        hit   = 1'b0;
        unique case (span)
            ram_write_guard_pkg::SPAN_OFF: hit = 1'b0;
            ram_write_guard_pkg::SPAN_128: hit = (addr >= start) && (offs < 20'h00080);
            ram_write_guard_pkg::SPAN_256: hit = (addr >= start) && (offs < 20'h00100);
            ram_write_guard_pkg::SPAN_512: hit = (addr >= start) && (offs < 20'h00200);
        endcase
    end
endmodule
`default_nettype wire

// [ram_write_guard.sv]
`timescale 1ns/100ps
`default_nettype none
module ram_write_guard #(
    parameter int ADDR_W = 20, // access address width
    parameter int DATA_W = 8   // register width
) (
    input  wire logic                             clk_sys,     // system clock
    input  wire logic                             resetn,      // sync reset, low
    input  wire ram_write_guard_pkg::mem_req_type cpu_req,     // cpu data access
    input  wire logic                             cpu_byte,    // access is 8-bit
    output logic                                  ram_wr_en,   // write passed to ram
    output logic [7:0]                            reg_rdata,   // register read data
    output logic                                  reg_hit,     // access hit a register
    output logic [7:0]                            guard_ctrl,  // control register value
    output logic [7:0]                            ram_base_bits // base register value
);
    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    ////////////////////////////////////////////////////////////////////////
    // the struct carrier fixes the address at 20 bits
    if (ADDR_W != 20)
    begin : g_bad_addr_w
        $error("ram_write_guard serves 20-bit addresses only");
    end

    // both registers are single bytes
    if (DATA_W != 8)
    begin : g_bad_data_w
        $error("ram_write_guard registers are 8 bits wide");
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////
    // control register: span field plus other stored bits that gate nothing
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;

    // base register and its write-once lock
    logic [7:0]  base_reg;
    logic [7:0]  base_next;
    logic        base_locked_reg;
    logic        base_locked_next;

    // registered read data
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;

    // register decode
    logic        sel_ctrl;
    logic        sel_base;
    logic        byte_wr;
    logic        byte_rd;
    logic        ctrl_wr;
    logic        ctrl_rd;
    logic        base_wr;
    logic        base_rd;
    logic        base_take;

    // guarded span lookup and write gating
    logic [1:0]  span_sel;
    logic        in_span;
    logic        step_write;
    logic        ram_write;
    logic        write_dropped;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    ////////////////////////////////////////////////////////////////////////
    // registers answer only at their exact byte address
    assign sel_ctrl = cpu_req.addr == ram_write_guard_pkg::GUARD_CTRL_ADDR;
    assign sel_base = cpu_req.addr == ram_write_guard_pkg::BASE_SEL_ADDR;

    // wider accesses to a register are ignored
    assign byte_wr = cpu_req.wr && cpu_byte;
    assign byte_rd = cpu_req.rd && cpu_byte;

    assign ctrl_wr = byte_wr && sel_ctrl;
    assign ctrl_rd = byte_rd && sel_ctrl;
    assign base_wr = byte_wr && sel_base;
    assign base_rd = byte_rd && sel_base;

    // only the first base write after reset is taken
    assign base_take = base_wr && !base_locked_reg;

    ////////////////////////////////////////////////////////////////////////
    // guarded span lookup
    ////////////////////////////////////////////////////////////////////////
    // span follows the stored field; 00 leaves the span empty
    assign span_sel = ctrl_reg[ram_write_guard_pkg::SPAN_LSB +: 2];

    // base comes from base_reg, so the one taken base write moves the span from the next cycle
    span_match #(
        .ADDR_W (ADDR_W)
    ) span_match_i (
        .addr (cpu_req.addr),
        .base (base_reg),
        .span (span_sel),
        .hit  (in_span)
    );

    ////////////////////////////////////////////////////////////////////////
    // control register
    ////////////////////////////////////////////////////////////////////////
    // one stage per bit; unused positions are held at zero
    for (genvar i = 0; i < 8; i++)
    begin : g_ctrl_bit
        if (ram_write_guard_pkg::GUARD_CTRL_MASK[i])
        begin : g_stored
            assign ctrl_next[i] = ctrl_wr ? cpu_req.wdata[i] : ctrl_reg[i];
        end
        else
        begin : g_fixed
            assign ctrl_next[i] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ctrl_reg <= ram_write_guard_pkg::GUARD_CTRL_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // base register, written once per reset
    ////////////////////////////////////////////////////////////////////////
    // later writes leave both value and lock alone
    always_comb
    begin
        base_next        = base_reg;
        base_locked_next = base_locked_reg;
        if (base_take)
        begin
            base_next        = cpu_req.wdata;
            base_locked_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            base_reg        <= ram_write_guard_pkg::BASE_SEL_RESET;
            base_locked_reg <= 1'b0;
        end
        else
        begin
            base_reg        <= base_next;
            base_locked_reg <= base_locked_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read data
    ////////////////////////////////////////////////////////////////////////
    // held until the next register read
    always_comb
    begin
        rdata_next = rdata_reg;
        if (ctrl_rd)
        begin
            rdata_next = ctrl_reg;
        end
        else if (base_rd)
        begin
            rdata_next = base_reg;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ram write gating
    ////////////////////////////////////////////////////////////////////////
    // single-step debug writes bypass the guard
    assign step_write = cpu_req.wr && cpu_req.debug_step;

    // register addresses are never forwarded to ram
    assign ram_write = cpu_req.wr && !sel_ctrl && !sel_base;

    // in_span stays low while the span field is 00
    assign write_dropped = ram_write && in_span && !step_write;

    // a dropped write just vanishes: no fault, no flag; reads untouched
    assign ram_wr_en = ram_write && !write_dropped;

    ////////////////////////////////////////////////////////////////////////
    // register views
    ////////////////////////////////////////////////////////////////////////
    assign reg_hit       = sel_ctrl || sel_base;
    assign reg_rdata     = rdata_reg;
    assign guard_ctrl    = ctrl_reg;
    assign ram_base_bits = base_reg;
endmodule
`default_nettype wire

// [ram_write_guard_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module guard_checker (input wire logic clk_sys, resetn, cpu_byte, ram_wr_en, reg_hit,
    input wire logic [7:0] reg_rdata, guard_ctrl, ram_base_bits, input wire ram_write_guard_pkg::mem_req_type cpu_req);
    wire [7:0] wd = cpu_req.wdata;
    wire hit = |guard_ctrl[5:4] && cpu_req.addr - {4'hf, ram_base_bits, 8'h00} < (20'h40 << guard_ctrl[5:4]);
    wire ww = cpu_req.wr && !reg_hit;
    wire bw = cpu_req.wr && cpu_byte && cpu_req.addr == 20'hff076;
    wire cw = cpu_req.wr && cpu_byte && cpu_req.addr == 20'hf0078;
    wire cr = cpu_req.rd && cpu_byte && cpu_req.addr == 20'hf0078;
    logic lock;
    always_ff @(posedge clk_sys) lock <= resetn && (lock || bw);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_span_block: assert property (ww && hit && !cpu_req.debug_step |-> !ram_wr_en) else $error("leak");
    a_open_pass: assert property (ww && !hit |-> ram_wr_en) else $error("lost");
    a_debug_pass: assert property (ww && cpu_req.debug_step |-> ram_wr_en) else $error("debug");
    a_base_take: assert property (bw && !lock |=> ram_base_bits == $past(wd)) else $error("base");
    a_base_lock: assert property (lock |=> $stable(ram_base_bits)) else $error("lock");
    a_ctrl_write: assert property (cw |=> guard_ctrl == ($past(wd) & 8'hb7)) else $error("ctrl");
    a_wide_drop: assert property (cpu_req.wr && !cpu_byte |=> $stable(guard_ctrl)) else $error("wide");
    a_read_back: assert property (cr |=> reg_rdata == $past(guard_ctrl)) else $error("read");
endmodule
bind ram_write_guard guard_checker guard_checker_i (.clk_sys(clk_sys), .resetn(resetn), .cpu_byte(cpu_byte),
    .ram_wr_en(ram_wr_en), .reg_hit(reg_hit), .reg_rdata(reg_rdata), .guard_ctrl(guard_ctrl),
    .ram_base_bits(ram_base_bits), .cpu_req(cpu_req));
`default_nettype wire

// [cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_model (input wire logic clk_sys, ram_wr_en, reg_hit,
    output var ram_write_guard_pkg::mem_req_type cpu_req, output var logic cpu_byte);
    logic last_hit;
    initial {cpu_req, cpu_byte, last_hit} = '0;
    task automatic access(input logic w, input logic [19:0] a, input logic [7:0] d, input logic g, b, output logic en);
        @(negedge clk_sys);
        {cpu_req, cpu_byte} = {w, !w, g, a, d, b};
        #1 en = ram_wr_en;
        last_hit = reg_hit;
        @(negedge clk_sys);
        {cpu_req, cpu_byte} = {3'h0, ~a, ~d, b};
        repeat (2) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [ram_write_guard_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module ram_write_guard_tb;
    ram_write_guard_pkg::mem_req_type cpu_req;
    logic clk_sys = 1'b0, resetn = 1'b0, cpu_byte, ram_wr_en, reg_hit, e1, en;
    logic [7:0] reg_rdata, guard_ctrl, ram_base_bits;
    int fail_count = 0, checked = 0;
    ram_write_guard ram_write_guard_i (.clk_sys(clk_sys), .resetn(resetn), .cpu_req(cpu_req), .cpu_byte(cpu_byte),
        .ram_wr_en(ram_wr_en), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .guard_ctrl(guard_ctrl),
        .ram_base_bits(ram_base_bits));
    cpu_model cpu_model_i (.clk_sys(clk_sys), .ram_wr_en(ram_wr_en), .reg_hit(reg_hit), .cpu_req(cpu_req),
        .cpu_byte(cpu_byte));
    task automatic chk(input logic [15:0] got, exp);
        checked++;
        fail_count += int'(got !== exp);
        if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic report_and_stop(input int late);
        if (fail_count + late == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #25 clk_sys = ~clk_sys;
    initial #100000 report_and_stop(1);
    initial
    begin
        #1000 resetn = 1'b1;
        chk({guard_ctrl, ram_base_bits}, 16'h00ef);
        cpu_model_i.access(1, 20'hff076, 8'hdf, 0, 0, en);
        cpu_model_i.access(1, 20'hff076, 8'h9f, 0, 1, en);
        cpu_model_i.access(1, 20'hff076, 8'haf, 0, 1, en);
        chk(ram_base_bits, 8'h9f);
        for (int s = 0; s < 4; s++)
        begin
            cpu_model_i.access(1, 20'hf0078, {2'b11, s[1:0], 4'hf}, 0, 1, en);
            cpu_model_i.access(1, 20'hf9eff + (20'h40 << s), 8'h5a, 0, 1, e1);
            cpu_model_i.access(1, 20'hf9f00 + (20'h40 << s), 8'ha5, 0, 1, en);
            chk({guard_ctrl, 6'h0, e1, en}, {2'b10, s[1:0], 4'h7, 6'h0, s == 0, 1'b1});
        end
        cpu_model_i.access(1, 20'hf9f00, 8'h33, 1, 1, e1);
        cpu_model_i.access(1, 20'hf0078, 8'h00, 0, 0, en);
        cpu_model_i.access(0, 20'hf0078, 8'h00, 0, 1, en);
        chk({reg_rdata, 7'h0, e1}, 16'hb701);
        cpu_model_i.access(0, 20'hff076, 8'h00, 0, 1, en);
        chk({reg_rdata, 6'h0, cpu_model_i.last_hit, en}, 16'h9f02);
        report_and_stop(0);
    end
endmodule
`default_nettype wire
